// ==== cmpev_pkg.sv ====
// constants, encodings and register map of the comparator event logic
package cmpev_pkg;
    localparam int NUM_COMP = 3;
    localparam int AW       = 8;

    // register byte offsets
    localparam logic [7:0] ADDR_RAW   = 8'h00;
    localparam logic [7:0] ADDR_MASK  = 8'h04;
    localparam logic [7:0] ADDR_MIS   = 8'h08;
    localparam logic [7:0] ADDR_REF   = 8'h0c;
    localparam logic [7:0] ADDR_VALUE = 8'h10;
    localparam logic [7:0] ADDR_CTRL0 = 8'h20;

    // per-comparator control word layout
    localparam int CTRL_W     = 10;
    localparam int TRIG_LSB   = 0;
    localparam int INT_LSB    = 3;
    localparam int SRC_LSB    = 6;
    localparam int POL_LSB    = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

    // internal reference register layout
    localparam int REF_LVL_W   = 5;
    localparam int REF_EN_BIT  = 8;
    localparam logic [REF_LVL_W-1:0] REF_LVL_RST = 5'h00;
    localparam logic [REF_LVL_W-1:0] REF_LVL_MAX = 5'h1b;
    localparam logic                 REF_EN_RST  = 1'b0;

    localparam logic [NUM_COMP-1:0] MASK_RST = 3'h0;

    typedef enum logic [2:0] {
        COND_NONE = 3'h0,
        COND_HIGH = 3'h1,
        COND_LOW  = 3'h2,
        COND_FALL = 3'h3,
        COND_RISE = 3'h4,
        COND_BOTH = 3'h5
    } cmpev_cond_e;

    typedef enum logic [1:0] {
        SRC_OWN_PIN    = 2'h0,
        SRC_SHARED_PIN = 2'h1,
        SRC_INTERNAL   = 2'h2
    } cmpev_src_e;

    typedef enum logic [1:0] {
        POL_NORMAL = 2'h0,
        POL_INVERT = 2'h1,
        POL_LEGACY = 2'h2
    } cmpev_pol_e;
endpackage : cmpev_pkg

// ==== cmpev_sig_if.sv ====
// synchronised comparator level with its edge pulses
`timescale 1ns/1ps
interface cmpev_sig_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport snk (input level, input rise, input fall);
endinterface : cmpev_sig_if

// ==== cmpev_sync.sv ====
// two-stage synchroniser and edge detector for one comparator output
`timescale 1ns/1ps
module cmpev_sync (
    input  wire logic   clock,
    input  wire logic   reset,
    input  wire logic   async_in,
    cmpev_sig_if.src    sig
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // meta_r feeds sync_r only; the analog output has no relation to clock
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign sig.level = sync_r;
    assign sig.rise  = sync_r & ~prev_r;
    assign sig.fall  = ~sync_r & prev_r;
endmodule : cmpev_sync

// ==== cmpev_cond.sv ====
// evaluates one level or edge condition against a synchronised output
`timescale 1ns/1ps
module cmpev_cond
    import cmpev_pkg::*;
(
    input  wire logic [2:0] sel,
    cmpev_sig_if.snk        sig,
    output wire logic       hit
);
    wire is_high = (sel == COND_HIGH) & sig.level;
    wire is_low  = (sel == COND_LOW) & ~sig.level;
    wire is_fall = ((sel == COND_FALL) | (sel == COND_BOTH)) & sig.fall;
    wire is_rise = ((sel == COND_RISE) | (sel == COND_BOTH)) & sig.rise;

    // none and unused codes never hit
    assign hit = is_high | is_low | is_fall | is_rise;
endmodule : cmpev_cond

// ==== cmpev_top.sv ====
// comparator event logic: conditions, triggers, interrupt and wishbone registers
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

module cmpev_top
    import cmpev_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [AW-1:0]         wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic [NUM_COMP-1:0]   comp_out_async,
    output logic      [NUM_COMP-1:0]   comp_pin_out,
    output logic      [NUM_COMP-1:0]   adc_trigger,
    output logic      [2*NUM_COMP-1:0] reference_source_select,
    output logic                       ref_power_up,
    output logic      [REF_LVL_W-1:0]  ref_level,
    output logic                       irq
);
    logic [CTRL_W-1:0]    ctrl_r [NUM_COMP];
    logic [NUM_COMP-1:0]  raw_r;
    logic [NUM_COMP-1:0]  mask_r;
    logic                 ref_en_r;
    logic [REF_LVL_W-1:0] ref_lvl_r;
    logic                 ack_r;
    logic [31:0]          dat_r;
    logic [NUM_COMP-1:0]  trig_r;
    logic [NUM_COMP-1:0]  pin_r;
    logic [2*NUM_COMP-1:0] src_r;
    logic                 irq_r;
    logic                 pwr_r;
    logic [REF_LVL_W-1:0] lvl_out_r;

    logic [NUM_COMP-1:0]  lvl;
    logic [NUM_COMP-1:0]  rise;
    logic [NUM_COMP-1:0]  trig_hit;
    logic [NUM_COMP-1:0]  int_hit;
    logic [NUM_COMP-1:0]  ctrl_wr;
    logic [NUM_COMP-1:0]  pin_nxt;
    logic [2*NUM_COMP-1:0] src_nxt;
    logic [31:0]          ctrl_rd [NUM_COMP];

    // bus decode
    wire        req      = wb_cyc_i & wb_stb_i;
    wire        wr_go    = req & wb_we_i & ack_r;
    wire        rd_load  = req & ~ack_r;
    wire [31:0] byte_msk = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire        hit_raw  = (wb_adr_i == ADDR_RAW);
    wire        hit_mask = (wb_adr_i == ADDR_MASK);
    wire        hit_mis  = (wb_adr_i == ADDR_MIS);
    wire        hit_ref  = (wb_adr_i == ADDR_REF);
    wire        hit_val  = (wb_adr_i == ADDR_VALUE);
    wire        wr_raw   = wr_go & hit_raw;
    wire        wr_mask  = wr_go & hit_mask;
    wire        wr_ref   = wr_go & hit_ref;

    wire [NUM_COMP-1:0]  raw_clr  = wr_raw ? (wb_dat_i[NUM_COMP-1:0] & byte_msk[NUM_COMP-1:0])
                                           : {NUM_COMP{1'b0}};
    wire [NUM_COMP-1:0]  mask_nxt = (mask_r & ~byte_msk[NUM_COMP-1:0])
                                  | (wb_dat_i[NUM_COMP-1:0] & byte_msk[NUM_COMP-1:0]);
    wire [NUM_COMP-1:0]  mis      = raw_r & mask_r;
    // a new event in the clearing cycle survives the clear
    wire [NUM_COMP-1:0]  raw_nxt  = (raw_r & ~raw_clr) | int_hit;

    // reference level codes above the top step are held at the top step
    wire [REF_LVL_W-1:0] ref_req  = wb_sel_i[0] ? wb_dat_i[REF_LVL_W-1:0] : ref_lvl_r;
    wire [REF_LVL_W-1:0] lvl_nxt  = (ref_req > REF_LVL_MAX) ? REF_LVL_MAX : ref_req;
    wire                 en_nxt   = wb_sel_i[1] ? wb_dat_i[REF_EN_BIT] : ref_en_r;

    wire [31:0] rd_fixed = hit_raw  ? {{(32-NUM_COMP){1'b0}}, raw_r}
                         : hit_mask ? {{(32-NUM_COMP){1'b0}}, mask_r}
                         : hit_mis  ? {{(32-NUM_COMP){1'b0}}, mis}
                         : hit_ref  ? {23'h000000, ref_en_r, 3'h0, ref_lvl_r}
                         : hit_val  ? {{(32-NUM_COMP){1'b0}}, lvl}
                         : 32'h00000000;

    logic [31:0] rd_ctrl;
    always_comb begin
        rd_ctrl = 32'h00000000;
        for (int k = 0; k < NUM_COMP; k++) begin
            rd_ctrl = rd_ctrl | ctrl_rd[k];
        end
    end
    wire [31:0] rd_data = rd_fixed | rd_ctrl;

    // per comparator datapath
    for (genvar i = 0; i < NUM_COMP; i++) begin : g_comp
        cmpev_sig_if sig ();

        cmpev_sync u_sync (
            .clock    (clock),
            .reset    (reset),
            .async_in (comp_out_async[i]),
            .sig      (sig.src)
        );

        // two separate evaluators keep trigger and interrupt independent
        cmpev_cond u_trig (
            .sel (ctrl_r[i][TRIG_LSB +: 3]),
            .sig (sig.snk),
            .hit (trig_hit[i])
        );

        cmpev_cond u_int (
            .sel (ctrl_r[i][INT_LSB +: 3]),
            .sig (sig.snk),
            .hit (int_hit[i])
        );

        assign lvl[i]  = sig.level;
        assign rise[i] = sig.rise;

        localparam logic [7:0] CTRL_ADDR = ADDR_CTRL0 + 8'(4 * i);
        wire hit_ctrl   = (wb_adr_i == CTRL_ADDR);
        assign ctrl_wr[i] = wr_go & hit_ctrl;
        assign ctrl_rd[i] = hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_r[i]} : 32'h00000000;

        // legacy and unused polarity codes pass the true result
        wire inv = (ctrl_r[i][POL_LSB +: 2] == POL_INVERT);
        assign pin_nxt[i] = sig.level ^ inv;

        // comparator zero owns the shared pin, so shared folds onto own
        wire [1:0] src_sel = ctrl_r[i][SRC_LSB +: 2];
        assign src_nxt[2*i +: 2] = ((i == 0) && (src_sel == SRC_SHARED_PIN)) ? SRC_OWN_PIN
                                 : (src_sel == 2'h3) ? SRC_OWN_PIN : src_sel;

        always_ff @(posedge clock) begin
            if (reset) begin
                ctrl_r[i] <= CTRL_RST;
            end else if (ctrl_wr[i]) begin
                ctrl_r[i] <= (ctrl_r[i] & ~byte_msk[CTRL_W-1:0]) | (wb_dat_i[CTRL_W-1:0] & byte_msk[CTRL_W-1:0]);
            end
        end
    end

    // wishbone slave: ack one cycle after the request, write on the acked edge
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= req & ~ack_r;
            if (rd_load) begin
                dat_r <= rd_data;
            end
        end
    end

    // interrupt status, mask and forwarding
    always_ff @(posedge clock) begin
        if (reset) begin
            raw_r  <= {NUM_COMP{1'b0}};
            mask_r <= MASK_RST;
            irq_r  <= 1'b0;
        end else begin
            raw_r <= raw_nxt;
            if (wr_mask) begin
                mask_r <= mask_nxt;
            end
            irq_r <= |mis;
        end
    end

    // internal reference
    always_ff @(posedge clock) begin
        if (reset) begin
            ref_en_r  <= REF_EN_RST;
            ref_lvl_r <= REF_LVL_RST;
        end else if (wr_ref) begin
            ref_en_r  <= en_nxt;
            ref_lvl_r <= lvl_nxt;
        end
    end

    // registered outputs
    always_ff @(posedge clock) begin
        if (reset) begin
            trig_r    <= {NUM_COMP{1'b0}};
            pin_r     <= {NUM_COMP{1'b0}};
            src_r     <= {(2*NUM_COMP){1'b0}};
            pwr_r     <= 1'b0;
            lvl_out_r <= REF_LVL_RST;
        end else begin
            trig_r    <= trig_hit;
            pin_r     <= pin_nxt;
            src_r     <= src_nxt;
            pwr_r     <= ref_en_r;
            lvl_out_r <= ref_lvl_r;
        end
    end

    assign wb_ack_o                = ack_r;
    assign wb_dat_o                = dat_r;
    assign adc_trigger             = trig_r;
    assign comp_pin_out            = pin_r;
    assign reference_source_select = src_r;
    assign ref_power_up            = pwr_r;
    assign ref_level               = lvl_out_r;
    assign irq                     = irq_r;

    // checks on comparator zero, the interrupt line and the internal reference
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    wire [2:0] trig_sel0 = ctrl_r[0][TRIG_LSB +: 3];
    wire [2:0] int_sel0  = ctrl_r[0][INT_LSB +: 3];
    wire [1:0] pol0      = ctrl_r[0][POL_LSB +: 2];

    sequence s_clear0;
        wr_raw && wb_sel_i[0] && wb_dat_i[0] && !int_hit[0];
    endsequence
    sequence s_level_high0;
        (int_sel0 == COND_HIGH) && lvl[0];
    endsequence

    property p_trig_none;
        (trig_sel0 == COND_NONE) |=> !adc_trigger[0];
    endproperty
    a_trig_none: assert property (p_trig_none) else $error("trigger fired with none selected");

    property p_trig_low;
        (trig_sel0 == COND_LOW) && !lvl[0] && !ctrl_wr[0] |=> adc_trigger[0] && !lvl[0] || adc_trigger[0];
    endproperty
    a_trig_low: assert property (p_trig_low) else $error("low level did not trigger");

    property p_trig_rise;
        (trig_sel0 == COND_RISE) && rise[0] |=> adc_trigger[0] ##1 !adc_trigger[0] || $past(rise[0], 1);
    endproperty
    a_trig_rise: assert property (p_trig_rise) else $error("rising trigger not a single pulse");

    property p_indep;
        (trig_sel0 == COND_RISE) && (int_sel0 == COND_FALL) && $fell(lvl[0]) |=> raw_r[0] && !adc_trigger[0];
    endproperty
    a_indep: assert property (p_indep) else $error("trigger and interrupt conditions not independent");

    property p_int_level_reassert;
        s_level_high0 ##0 wr_raw && wb_dat_i[0] && wb_sel_i[0] |=> raw_r[0];
    endproperty
    a_int_level_reassert: assert property (p_int_level_reassert) else $error("level interrupt lost on clear");

    property p_int_clear;
        s_clear0 |=> !raw_r[0];
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("clear did not drop the interrupt");

    property p_int_fall;
        (int_sel0 == COND_FALL) && $fell(lvl[0]) |=> raw_r[0];
    endproperty
    a_int_fall: assert property (p_int_fall) else $error("falling edge not recorded");

    property p_irq_fwd;
        ((raw_r & mask_r) != 0) |=> irq;
    endproperty
    a_irq_fwd: assert property (p_irq_fwd) else $error("enabled pending interrupt not forwarded");

    property p_irq_block;
        ((raw_r & mask_r) == 0) |=> !irq;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("disabled interrupt forwarded");

    property p_pin_pol;
        (pol0 == POL_INVERT) |=> comp_pin_out[0] == !$past(lvl[0]);
    endproperty
    a_pin_pol: assert property (p_pin_pol) else $error("inverted pin wrong");

    property p_pin_legacy;
        (pol0 == POL_LEGACY) |=> comp_pin_out[0] == $past(lvl[0]);
    endproperty
    a_pin_legacy: assert property (p_pin_legacy) else $error("legacy polarity not normal");

    property p_src0;
        (ctrl_r[0][SRC_LSB +: 2] == SRC_SHARED_PIN) |=> reference_source_select[1:0] == SRC_OWN_PIN;
    endproperty
    a_src0: assert property (p_src0) else $error("comparator zero shared source not folded");

    property p_value_read;
        rd_load && hit_val |=> wb_ack_o && wb_dat_o[0] == $past(lvl[0]);
    endproperty
    a_value_read: assert property (p_value_read) else $error("value read wrong");

    property p_mis_read;
        rd_load && hit_mis |=> wb_dat_o[NUM_COMP-1:0] == $past(raw_r & mask_r);
    endproperty
    a_mis_read: assert property (p_mis_read) else $error("masked status read wrong");

    property p_ref_off;
        !ref_en_r |=> !ref_power_up;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference powered while off");

    property p_edge_pulse;
        rise[0] |=> !rise[0];
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse longer than one cycle");

    property p_trig_high;
        (trig_sel0 == COND_HIGH) && lvl[0] |=> adc_trigger[0];
    endproperty
    a_trig_high: assert property (p_trig_high) else $error("high level did not trigger");

    property p_trig_fall;
        (trig_sel0 == COND_FALL) && $fell(lvl[0]) |=> adc_trigger[0];
    endproperty
    a_trig_fall: assert property (p_trig_fall) else $error("falling edge did not trigger");

    property p_int_high;
        (int_sel0 == COND_HIGH) && lvl[0] |=> raw_r[0];
    endproperty
    a_int_high: assert property (p_int_high) else $error("high level not recorded");

    property p_int_low;
        (int_sel0 == COND_LOW) && !lvl[0] |=> raw_r[0];
    endproperty
    a_int_low: assert property (p_int_low) else $error("low level not recorded");

    property p_ref_clamp;
        wr_ref |=> (ref_lvl_r <= REF_LVL_MAX);
    endproperty
    a_ref_clamp: assert property (p_ref_clamp) else $error("reference level above the top step");

    // two edges after reset the flushed stages still hold zero, so the check waits for them
    property p_sync_lat;
        !$past(reset) && !$past(reset, 2) |-> lvl[0] == $past(comp_out_async[0], 2);
    endproperty
    a_sync_lat: assert property (p_sync_lat) else $error("comparator output not taken through two stages");
endmodule : cmpev_top

// ==== cmpev_adc_model.sv ====
// far-side model: converter sequencer that counts trigger cycles per comparator
`timescale 1ns/1ps
module cmpev_adc_model
    import cmpev_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     clr,
    input  wire logic                     cnt_en,
    input  wire logic [NUM_COMP-1:0]      adc_trigger,
    output logic      [NUM_COMP-1:0][7:0] trig_cnt
);
    // one count per sampled cycle: a level trigger counts its length, an edge pulse counts once
    always_ff @(posedge clock) begin
        for (int i = 0; i < NUM_COMP; i++) begin
            if (clr) begin
                trig_cnt[i] <= 8'h00;
            end else if (cnt_en && adc_trigger[i]) begin
                trig_cnt[i] <= trig_cnt[i] + 8'h01;
            end
        end
    end
endmodule : cmpev_adc_model

// ==== cmpev_top_tb.sv ====
// self-checking testbench of the comparator event logic
`timescale 1ns/1ps
module cmpev_top_tb;
    import cmpev_pkg::*;
    typedef struct {
        int ci; logic [2:0] trig; logic [2:0] intc; logic [1:0] src; logic [1:0] pol;
        logic [7:0] cnt; logic raw; logic [1:0] srco; logic pin;
    } cmpev_row_s;
    logic                     clock = 1'b0;
    logic                     reset = 1'b1;
    logic                     wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [AW-1:0]            wb_adr_i = 8'h00;
    logic [3:0]               wb_sel_i = 4'hf;
    logic [31:0]              wb_dat_i = 32'h0, wb_dat_o, rd;
    logic                     wb_ack_o, ref_power_up, irq;
    logic [NUM_COMP-1:0]      comp_out_async = 3'h0, comp_pin_out, adc_trigger;
    logic [2*NUM_COMP-1:0]    reference_source_select;
    logic [REF_LVL_W-1:0]     ref_level;
    logic                     clr = 1'b0, cnt_en = 1'b0;
    logic [NUM_COMP-1:0][7:0] trig_cnt;
    int                       n_mismatch = 0, checks_done = 0;
    // input pattern of every row: 10 cycles high, 10 low, counted over 20 cycles
    cmpev_row_s rows [8] = '{
        '{0, 3'h0, 3'h0, 2'h1, 2'h0, 8'd0,  1'b0, 2'h0, 1'b0},
        '{0, 3'h1, 3'h1, 2'h1, 2'h1, 8'd10, 1'b1, 2'h0, 1'b1},
        '{0, 3'h2, 3'h2, 2'h2, 2'h2, 8'd10, 1'b1, 2'h2, 1'b0},
        '{0, 3'h3, 3'h3, 2'h0, 2'h3, 8'd1,  1'b1, 2'h0, 1'b0},
        '{1, 3'h4, 3'h4, 2'h3, 2'h0, 8'd1,  1'b1, 2'h0, 1'b0},
        '{2, 3'h5, 3'h5, 2'h1, 2'h1, 8'd2,  1'b1, 2'h1, 1'b1},
        '{0, 3'h6, 3'h6, 2'h2, 2'h0, 8'd0,  1'b0, 2'h2, 1'b0},
        '{1, 3'h7, 3'h7, 2'h0, 2'h0, 8'd0,  1'b0, 2'h0, 1'b0}};
    logic [9:0] ctrl;

    always #5 clock = ~clock;

    cmpev_top dut_u (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_out_async(comp_out_async),
        .comp_pin_out(comp_pin_out), .adc_trigger(adc_trigger),
        .reference_source_select(reference_source_select), .ref_power_up(ref_power_up),
        .ref_level(ref_level), .irq(irq));
    cmpev_adc_model adc_u (.clock(clock), .clr(clr), .cnt_en(cnt_en), .adc_trigger(adc_trigger),
        .trig_cnt(trig_cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // classic cycle: hold everything until ack is sampled, then release for one idle edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int t;
        @(posedge clock);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= dat;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        if (t >= 50) chk(32'h1, 32'h0);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    endtask : wb

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rdchk(ADDR_RAW, 32'h0);
        rdchk(ADDR_MASK, 32'h0);
        rdchk(ADDR_REF, 32'h0);
        rdchk(ADDR_CTRL0, 32'h0);
        rdchk(8'h40, 32'h0);
        chk({irq, adc_trigger, ref_power_up}, 32'h0);
        $display("test reset done");
        foreach (rows[k]) begin
            ctrl = {rows[k].pol, rows[k].src, rows[k].intc, rows[k].trig};
            wb(1'b1, ADDR_CTRL0 + 8'(4 * rows[k].ci), {22'h0, ctrl});
            rdchk(ADDR_CTRL0 + 8'(4 * rows[k].ci), {22'h0, ctrl});
            wb(1'b1, ADDR_RAW, 32'h7);
            repeat (5) @(posedge clock);
            clr <= 1'b1;
            @(posedge clock);
            clr <= 1'b0; cnt_en <= 1'b1; comp_out_async[rows[k].ci] <= 1'b1;
            repeat (10) @(posedge clock);
            comp_out_async[rows[k].ci] <= 1'b0;
            repeat (10) @(posedge clock);
            cnt_en <= 1'b0;
            repeat (3) @(posedge clock);
            chk(trig_cnt[rows[k].ci], rows[k].cnt);
            wb(1'b0, ADDR_RAW, 32'h0);
            chk(rd[rows[k].ci], rows[k].raw);
            chk(comp_pin_out[rows[k].ci], rows[k].pin);
            chk(reference_source_select[2*rows[k].ci +: 2], rows[k].srco);
        end
        $display("test table done");
        wb(1'b1, ADDR_REF, 32'h11f);
        rdchk(ADDR_REF, 32'h11b);
        repeat (2) @(posedge clock);
        chk({ref_power_up, ref_level}, {26'h0, 1'b1, REF_LVL_MAX});
        wb(1'b1, ADDR_REF, 32'h003);
        repeat (2) @(posedge clock);
        chk({ref_power_up, ref_level}, 32'h03);
        $display("test reference done");
        wb(1'b1, ADDR_CTRL0, 32'h08);
        wb(1'b1, ADDR_RAW, 32'h7);
        comp_out_async[0] <= 1'b1;
        repeat (6) @(posedge clock);
        rdchk(ADDR_RAW, 32'h1);
        rdchk(ADDR_MIS, 32'h0);
        chk(irq, 1'b0);
        wb(1'b1, ADDR_MASK, 32'h1);
        repeat (2) @(posedge clock);
        chk(irq, 1'b1);
        rdchk(ADDR_MIS, 32'h1);
        // handler reads the masked status first, then clears while the level is still high
        wb(1'b1, ADDR_RAW, 32'h1);
        rdchk(ADDR_RAW, 32'h1);
        rdchk(ADDR_VALUE, 32'h1);
        comp_out_async[0] <= 1'b0;
        repeat (6) @(posedge clock);
        rdchk(ADDR_VALUE, 32'h0);
        wb(1'b1, ADDR_RAW, 32'h1);
        rdchk(ADDR_RAW, 32'h0);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        $display("test interrupt done");
        wb(1'b1, ADDR_CTRL0, 32'h1c);
        wb(1'b1, ADDR_RAW, 32'h7);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0; cnt_en <= 1'b1; comp_out_async[0] <= 1'b1;
        repeat (8) @(posedge clock);
        rdchk(ADDR_RAW, 32'h0);
        comp_out_async[0] <= 1'b0;
        repeat (8) @(posedge clock);
        rdchk(ADDR_RAW, 32'h1);
        chk(trig_cnt[0], 8'd1);
        cnt_en <= 1'b0;
        $display("test independence done");
        reset <= 1'b1;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rdchk(ADDR_MASK, 32'h0);
        rdchk(ADDR_CTRL0, 32'h0);
        rdchk(ADDR_REF, 32'h0);
        chk({irq, ref_power_up, ref_level}, 32'h0);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule : cmpev_top_tb
